// ### core/vta_consts.svh
// Constants for the vibration trigger and alarm controller
// Operation
// - Trigger source is none, digital or analog; digital and analog each use a selectable channel.
// - With no trigger source, cycles start as soon as configuration is applied.
// - With a trigger source, cycles wait for a valid trigger event.
// - Digital trigger is level sensitive with selectable active polarity.
// - Idle process with digital input active starts a cycle, even at start.
// - Analog trigger condition is above or below the trigger level.
// - Trigger conditions during a running cycle are ignored, never queued.
// - Trigger level matters only for an analog trigger source.
// - Analog trigger filter length is a count of consecutive samples.
// - Analog trigger fires only if every sample in the window passes.
// - Logging, feature and inference modes are exclusive in their functions.
// - Data logging mode is selected after startup.
// - Feature mode computes max, min, peak, peak-to-peak, RMS; checks enabled ones.
// - A failing channel drives its same-index alarm output high.
// - A passing channel holds its alarm output low.
// - Inference mode yields a pass or fail verdict per channel each cycle.
// - Score is the percentage of passes over the last N iterations.
// - Inference alarm rises when score is strictly below threshold.
// - Cycle is acquisition, then judgement, then output; next follows at once.
// - Section length sets samples per channel acquired each cycle.
// - Non-zero cycle count sets cycles run per accepted trigger.
// - Zero cycle count runs continuously while the trigger gates the run.
`ifndef VTA_CONSTS_SVH
`define VTA_CONSTS_SVH
`define VTA_NCH       4
`define VTA_SW        16
`define VTA_FILT_W    8
`define VTA_WIN_W     8
`define VTA_THR_W     7
`define VTA_ACC_W     48
`define VTA_NFEAT     5
`define VTA_SRC_NONE  2'h0
`define VTA_SRC_DIG   2'h1
`define VTA_SRC_ANA   2'h2
`define VTA_MODE_LOG  2'h0
`define VTA_MODE_FEAT 2'h1
`define VTA_MODE_INF  2'h2
`define VTA_PH_IDLE   2'h0
`define VTA_PH_ACQ    2'h1
`define VTA_PH_CALC   2'h3
`define VTA_PH_OUT    2'h2
`define VTA_F_MAX     0
`define VTA_F_MIN     1
`define VTA_F_PEAK    2
`define VTA_F_P2P     3
`define VTA_F_RMS     4
`define VTA_PCT       7'h64
`define VTA_SMP_MIN   16'h8000
`define VTA_SMP_MAX   16'h7FFF
`endif

// ### core/vta_pkg.sv
// Types and shared arithmetic of the vibration trigger and alarm controller
`include "vta_consts.svh"
package vta_pkg;
    typedef enum logic [1:0] {
        VTA_IDLE = `VTA_PH_IDLE,
        VTA_ACQ  = `VTA_PH_ACQ,
        VTA_CALC = `VTA_PH_CALC,
        VTA_OUT  = `VTA_PH_OUT
    } vta_phase_t;
    typedef logic signed [`VTA_SW-1:0] vta_smp_t;
    typedef vta_smp_t [`VTA_NCH-1:0]   vta_smp_vec_t;
    typedef vta_smp_t [`VTA_NFEAT-1:0] vta_lim_vec_t;
    typedef logic [`VTA_SW:0]          vta_mag_t;

    function automatic vta_mag_t vta_abs(input vta_smp_t s);
        logic signed [`VTA_SW:0] e;
        e = {s[`VTA_SW-1], s};
        vta_abs = e[`VTA_SW] ? vta_mag_t'(-e) : vta_mag_t'(e);
    endfunction : vta_abs

    function automatic logic [2*`VTA_SW-1:0] vta_sq(input vta_smp_t s);
        logic [2*`VTA_SW+1:0] p;
        p = vta_abs(s) * vta_abs(s);
        vta_sq = p[2*`VTA_SW-1:0];
    endfunction : vta_sq
endpackage : vta_pkg

// ### core/vta_if.sv
// Interface joining the controller to its trigger and score modules
`timescale 1ns/1ps
`default_nettype none
interface vta_if;
    import vta_pkg::*;
    logic [1:0]              src;
    logic [1:0]              ch;
    logic                    act_high;
    logic                    above;
    vta_smp_t                level;
    logic [`VTA_FILT_W-1:0]  filt_len;
    vta_smp_vec_t            sample;
    logic                    sample_valid;
    logic [`VTA_NCH-1:0]     din;
    logic                    trig_hit;
    logic                    push;
    logic [`VTA_NCH-1:0]     fail;
    logic                    clear;
    logic [`VTA_WIN_W-1:0]   win_len;
    logic [`VTA_THR_W-1:0]   thresh;
    logic [`VTA_NCH-1:0]     score_alarm;
    modport ctrl  (output src, ch, act_high, above, level, filt_len, sample, sample_valid, din,
                   push, fail, clear, win_len, thresh, input trig_hit, score_alarm);
    modport trig  (input src, ch, act_high, above, level, filt_len, sample, sample_valid, din,
                   output trig_hit);
    modport score (input push, fail, clear, win_len, thresh, output score_alarm);
endinterface : vta_if
`default_nettype wire

// ### core/vta_trigger.sv
// Trigger detector: digital level or filtered analog threshold
`timescale 1ns/1ps
`default_nettype none
module vta_trigger (
    input wire logic clk_in,
    input wire logic reset_n_in,
    vta_if.trig      bus
);
    import vta_pkg::*;
    typedef struct packed {
        logic [`VTA_FILT_W-1:0] cnt;
        logic                   hit;
    } vta_trig_st_t;
    vta_trig_st_t           s_reg;
    vta_trig_st_t           s_next;
    vta_smp_t               smp;
    logic                   cond;
    logic [`VTA_FILT_W-1:0] need;

    always_comb begin
        smp    = vta_smp_t'(bus.sample[bus.ch]);
        need   = (bus.filt_len == '0) ? `VTA_FILT_W'(1) : bus.filt_len;
        cond   = bus.above ? (smp > bus.level) : (smp < bus.level);
        s_next = s_reg;
        if (bus.src == `VTA_SRC_DIG) begin
            s_next.cnt = '0;
            s_next.hit = (bus.din[bus.ch] == bus.act_high);
        end else if (bus.src == `VTA_SRC_ANA) begin
            if (bus.sample_valid) begin
                if (cond) begin
                    if (s_reg.cnt != '1) begin
                        s_next.cnt = s_reg.cnt + 1'b1;
                    end
                    s_next.hit = (s_next.cnt >= need);
                end else begin
                    s_next.cnt = '0;
                    s_next.hit = 1'b0;
                end
            end
        end else begin
            s_next.cnt = '0;
            s_next.hit = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.trig_hit = s_reg.hit;
endmodule : vta_trigger
`default_nettype wire

// ### core/vta_score.sv
// Rolling pass score over the last N verdicts per channel
`timescale 1ns/1ps
`default_nettype none
module vta_score #(
    parameter int HIST_N = 255
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    vta_if.score     bus
);
    import vta_pkg::*;
    typedef struct packed {
        logic [`VTA_NCH-1:0][HIST_N-1:0]     hist;
        logic [`VTA_WIN_W-1:0]               fill;
        logic [`VTA_NCH-1:0][`VTA_WIN_W-1:0] pass;
        logic [`VTA_NCH-1:0]                 alarm;
    } vta_score_st_t;
    vta_score_st_t         s_reg;
    vta_score_st_t         s_next;
    logic [`VTA_WIN_W-1:0] n;
    logic [`VTA_NCH-1:0]   drop;

    function automatic logic below(input logic [`VTA_WIN_W-1:0] p, input logic [`VTA_WIN_W-1:0] f,
                                   input logic [`VTA_THR_W-1:0] t);
        logic [`VTA_WIN_W+`VTA_THR_W-1:0] l;
        logic [`VTA_WIN_W+`VTA_THR_W-1:0] r;
        l     = p * `VTA_PCT;
        r     = f * t;
        below = (l < r);
    endfunction : below

    always_comb begin
        n      = (bus.win_len == '0) ? `VTA_WIN_W'(1) : bus.win_len;
        drop   = '0;
        s_next = s_reg;
        if (bus.clear) begin
            s_next = '0;
        end else if (bus.push) begin
            for (int c = 0; c < `VTA_NCH; c++) begin
                drop[c]        = (s_reg.fill == n) & s_reg.hist[c][n-1'b1];
                s_next.hist[c] = {s_reg.hist[c][HIST_N-2:0], ~bus.fail[c]};
                s_next.pass[c] = s_reg.pass[c] + `VTA_WIN_W'(!bus.fail[c])
                                 - `VTA_WIN_W'(drop[c]);
            end
            if (s_reg.fill != n) begin
                s_next.fill = s_reg.fill + 1'b1;
            end
        end
        for (int c = 0; c < `VTA_NCH; c++) begin
            s_next.alarm[c] = below(s_next.pass[c], s_next.fill, bus.thresh);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.score_alarm = s_reg.alarm;
endmodule : vta_score
`default_nettype wire

// ### core/vta_ctrl.sv
// Top: iteration sequencer, feature judgement and alarm outputs
`timescale 1ns/1ps
`default_nettype none
module vta_ctrl #(
    parameter int SECT_W = 12,
    parameter int CNT_W  = 16,
    parameter int HIST_N = 255
) (
    input  wire logic                                 clk_in,
    input  wire logic                                 reset_n_in,
    input  wire logic                                 apply_in,
    input  wire logic                                 stop_in,
    input  wire logic [1:0]                           mode_in,
    input  wire logic [1:0]                           trig_src_in,
    input  wire logic [1:0]                           trig_ch_in,
    input  wire logic                                 dig_active_high_in,
    input  wire logic                                 ana_above_in,
    input  wire vta_pkg::vta_smp_t                    trig_level_in,
    input  wire logic [`VTA_FILT_W-1:0]               filter_len_in,
    input  wire logic [SECT_W-1:0]                    section_len_in,
    input  wire logic [CNT_W-1:0]                     cycle_count_in,
    input  wire logic [`VTA_NCH-1:0]                  din_in,
    input  wire vta_pkg::vta_smp_vec_t                sample_in,
    input  wire logic                                 sample_valid_in,
    input  wire logic [`VTA_NFEAT-1:0]                feat_en_in,
    input  wire vta_pkg::vta_lim_vec_t                feat_limit_in,
    input  wire logic [`VTA_NCH-1:0]                  fail_verdict_in,
    input  wire logic [`VTA_WIN_W-1:0]                window_len_in,
    input  wire logic [`VTA_THR_W-1:0]                score_thresh_in,
    output var  logic [`VTA_NCH-1:0]                  alarm_out,
    output var  logic [`VTA_NCH-1:0]                  fail_verdict_out,
    output var  logic                                 running_out,
    output var  logic                                 armed_out,
    output var  vta_pkg::vta_phase_t                  phase_out,
    output var  logic                                 cycle_done_out,
    output var  logic [CNT_W-1:0]                     iter_count_out,
    output var  vta_pkg::vta_smp_vec_t                feat_max_out,
    output var  vta_pkg::vta_smp_vec_t                feat_min_out,
    output var  logic [`VTA_NCH-1:0][`VTA_SW:0]       feat_peak_out,
    output var  logic [`VTA_NCH-1:0][`VTA_SW:0]       feat_p2p_out
);
    import vta_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        vta_phase_t                           phase;
        logic                                 running;
        logic                                 armed;
        logic [1:0]                           mode;
        logic [CNT_W-1:0]                     left;
        logic [SECT_W-1:0]                    nsmp;
        vta_smp_vec_t                         mx;
        vta_smp_vec_t                         mn;
        logic [`VTA_NCH-1:0][`VTA_SW:0]       pk;
        logic [`VTA_NCH-1:0][`VTA_ACC_W-1:0]  ssq;
        logic [`VTA_NCH-1:0]                  ffail;
        logic [`VTA_NCH-1:0]                  alarm;
        logic                                 done;
        logic [CNT_W-1:0]                     iters;
        vta_smp_vec_t                         f_max;
        vta_smp_vec_t                         f_min;
        logic [`VTA_NCH-1:0][`VTA_SW:0]       f_pk;
        logic [`VTA_NCH-1:0][`VTA_SW:0]       f_p2p;
    } vta_ctrl_st_t;

    vta_ctrl_st_t          s_reg;
    vta_ctrl_st_t          s_next;

    logic                  start;
    logic                  go_on;
    logic                  src_none;
    logic [SECT_W-1:0]     nsec;
    logic [`VTA_ACC_W-1:0] rms_bound;
    vta_smp_t              x;
    vta_mag_t              a;

    vta_if bus ();

    // ************************************************************
    // Submodules
    // ************************************************************
    vta_trigger u_trig (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .bus        (bus.trig)
    );

    vta_score #(
        .HIST_N (HIST_N)
    ) u_score (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .bus        (bus.score)
    );

    assign bus.src          = trig_src_in;
    assign bus.ch           = trig_ch_in;
    assign bus.act_high     = dig_active_high_in;
    assign bus.above        = ana_above_in;
    assign bus.level        = trig_level_in;
    assign bus.filt_len     = filter_len_in;
    assign bus.sample       = sample_in;
    assign bus.sample_valid = sample_valid_in;
    assign bus.din          = din_in;

    // Score module inputs
    assign bus.win_len      = window_len_in;
    assign bus.thresh       = score_thresh_in;
    assign bus.clear        = apply_in;
    assign bus.fail         = fail_verdict_in;
    assign bus.push         = (s_reg.phase == VTA_CALC) && (s_reg.mode == `VTA_MODE_INF);

    // ************************************************************
    // Feature helpers
    // ************************************************************
    function automatic vta_mag_t span(input vta_smp_t hi, input vta_smp_t lo);
        logic signed [`VTA_SW:0] d;
        d    = {hi[`VTA_SW-1], hi} - {lo[`VTA_SW-1], lo};
        span = vta_mag_t'(d);
    endfunction : span

    function automatic logic over(input vta_mag_t v, input vta_smp_t lim);
        over = ($signed({1'b0, v}) > lim);
    endfunction : over

    always_comb begin
        rms_bound = `VTA_ACC_W'(vta_sq(vta_smp_t'(feat_limit_in[`VTA_F_RMS])))
                    * `VTA_ACC_W'(nsec);
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        nsec     = (section_len_in == '0) ? SECT_W'(1) : section_len_in;
        src_none = (trig_src_in == `VTA_SRC_NONE);
        start    = 1'b0;
        go_on    = 1'b0;
        x        = '0;
        a        = '0;
        s_next   = s_reg;
        s_next.done = 1'b0;

        if (stop_in) begin
            s_next.armed = 1'b0;
        end else if (apply_in) begin
            s_next.armed = 1'b1;
            s_next.mode  = mode_in;
        end

        case (s_reg.phase)
            VTA_IDLE: begin
                if (s_reg.armed && (src_none || bus.trig_hit)) begin
                    start       = 1'b1;
                    s_next.left = cycle_count_in;
                end
            end

            VTA_ACQ: begin
                if (sample_valid_in) begin
                    for (int c = 0; c < `VTA_NCH; c++) begin
                        x = vta_smp_t'(sample_in[c]);
                        a = vta_abs(x);

                        if (x > vta_smp_t'(s_reg.mx[c])) begin
                            s_next.mx[c] = x;
                        end

                        if (x < vta_smp_t'(s_reg.mn[c])) begin
                            s_next.mn[c] = x;
                        end

                        if (a > s_reg.pk[c]) begin
                            s_next.pk[c] = a;
                        end

                        s_next.ssq[c] = s_reg.ssq[c] + `VTA_ACC_W'(vta_sq(x));
                    end

                    if ((s_reg.nsmp + 1'b1) == nsec) begin
                        s_next.phase = VTA_CALC;
                    end else begin
                        s_next.nsmp = s_reg.nsmp + 1'b1;
                    end
                end
            end

            VTA_CALC: begin
                for (int c = 0; c < `VTA_NCH; c++) begin
                    s_next.f_max[c] = s_reg.mx[c];
                    s_next.f_min[c] = s_reg.mn[c];
                    s_next.f_pk[c]  = s_reg.pk[c];
                    s_next.f_p2p[c] = span(s_reg.mx[c], s_reg.mn[c]);

                    case (s_reg.mode)
                        `VTA_MODE_FEAT: begin
                            s_next.ffail[c] =
                                (feat_en_in[`VTA_F_MAX] &&
                                 (vta_smp_t'(s_reg.mx[c]) > vta_smp_t'(feat_limit_in[`VTA_F_MAX])))
                              || (feat_en_in[`VTA_F_MIN] &&
                                 (vta_smp_t'(s_reg.mn[c]) < vta_smp_t'(feat_limit_in[`VTA_F_MIN])))
                              || (feat_en_in[`VTA_F_PEAK] &&
                                 over(s_reg.pk[c], vta_smp_t'(feat_limit_in[`VTA_F_PEAK])))
                              || (feat_en_in[`VTA_F_P2P] &&
                                 over(span(s_reg.mx[c], s_reg.mn[c]),
                                      vta_smp_t'(feat_limit_in[`VTA_F_P2P])))
                              || (feat_en_in[`VTA_F_RMS] && (s_reg.ssq[c] > rms_bound));
                        end
                        `VTA_MODE_INF: begin
                            s_next.ffail[c] = fail_verdict_in[c];
                        end
                        default: begin
                            s_next.ffail[c] = 1'b0;
                        end
                    endcase
                end

                s_next.phase = VTA_OUT;
            end

            VTA_OUT: begin
                case (s_reg.mode)
                    `VTA_MODE_FEAT: begin
                        s_next.alarm = s_reg.ffail;
                    end
                    `VTA_MODE_INF: begin
                        s_next.alarm = bus.score_alarm;
                    end
                    default: begin
                        s_next.alarm = '0;
                    end
                endcase

                s_next.done  = 1'b1;
                s_next.iters = s_reg.iters + 1'b1;

                if (s_reg.left == '0) begin
                    go_on = s_next.armed && (src_none || bus.trig_hit);
                end else if (s_reg.left == CNT_W'(1)) begin
                    go_on = 1'b0;
                    if (src_none && !apply_in) begin
                        s_next.armed = 1'b0;
                    end
                end else begin
                    go_on       = s_next.armed;
                    s_next.left = s_reg.left - 1'b1;
                end

                if (go_on) begin
                    start = 1'b1;
                end else begin
                    s_next.phase = VTA_IDLE;
                end
            end

            default: begin
                s_next.phase = VTA_IDLE;
            end
        endcase

        // Fresh accumulators for a new acquisition
        if (start) begin
            s_next.phase = VTA_ACQ;
            s_next.nsmp  = '0;
            s_next.pk    = '0;
            s_next.ssq   = '0;

            for (int c = 0; c < `VTA_NCH; c++) begin
                s_next.mx[c] = `VTA_SMP_MIN;
                s_next.mn[c] = `VTA_SMP_MAX;
            end
        end
        s_next.running = (s_next.phase != VTA_IDLE);
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_reg      <= '0;
            s_reg.mode <= `VTA_MODE_LOG;
        end else begin
            s_reg <= s_next;
        end
    end

    assign alarm_out        = s_reg.alarm;
    assign fail_verdict_out = s_reg.ffail;

    assign running_out      = s_reg.running;
    assign armed_out        = s_reg.armed;
    assign phase_out        = s_reg.phase;
    assign cycle_done_out   = s_reg.done;
    assign iter_count_out   = s_reg.iters;

    assign feat_max_out     = s_reg.f_max;
    assign feat_min_out     = s_reg.f_min;
    assign feat_peak_out    = s_reg.f_pk;
    assign feat_p2p_out     = s_reg.f_p2p;
endmodule : vta_ctrl
`default_nettype wire

// ### bench/vta_sensor.sv
// Behavioural sensor channels and digital inputs at the far side
`timescale 1ns/1ps
`default_nettype none
module vta_sensor (
    input  wire logic                  clk_in,
    input  wire logic [15:0]           amp_in,
    input  wire logic [3:0]            lvl_in,
    output var  logic [3:0]            din_out,
    output var  vta_pkg::vta_smp_vec_t sample_out,
    output var  logic                  sample_valid_out
);
    initial begin
        sample_valid_out = 1'b0;
        sample_out       = '0;
        din_out          = 4'hF;
    end
    // Samples valid every other cycle, inverse pattern between them
    always @(negedge clk_in) begin
        sample_valid_out <= ~sample_valid_out;
        sample_out       <= sample_valid_out ? ~{4{amp_in}} : {4{amp_in}};
        din_out          <= lvl_in;
    end
endmodule : vta_sensor
`default_nettype wire

// ### bench/vta_ctrl_assertions.sv
// Concurrent checks on the ports of the trigger and alarm controller
`timescale 1ns/1ps
`default_nettype none
`include "vta_consts.svh"
module vta_ctrl_assertions (
    input wire logic                clk_in,
    input wire logic                reset_n_in,
    input wire logic                apply_in,
    input wire logic                stop_in,
    input wire logic [1:0]          trig_src_in,
    input wire logic [1:0]          trig_ch_in,
    input wire logic                dig_active_high_in,
    input wire logic [`VTA_NCH-1:0] din_in,
    input wire logic [`VTA_NCH-1:0] alarm_out,
    input wire logic                running_out,
    input wire logic                armed_out,
    input wire vta_pkg::vta_phase_t phase_out,
    input wire logic                cycle_done_out
);
    import vta_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic idle;
    logic dig_on;
    assign idle   = phase_out == VTA_IDLE;
    assign dig_on = armed_out && idle && !stop_in && trig_src_in == `VTA_SRC_DIG;
    sequence s_finish;
        phase_out == VTA_CALC ##1 phase_out == VTA_OUT;
    endsequence
    chk_run_phase: assert property (running_out == !idle)
        else $error("running flag disagrees with phase");
    chk_acq_next: assert property (phase_out == VTA_ACQ |=> phase_out inside {VTA_ACQ, VTA_CALC})
        else $error("acquisition left wrongly");
    chk_done_pulse: assert property (s_finish |=> cycle_done_out ##1 !cycle_done_out)
        else $error("cycle done pulse missing after output");
    chk_alarm_at_out: assert property ($changed(alarm_out) |-> $past(phase_out) == VTA_OUT)
        else $error("alarm changed outside output phase");
    chk_none_start: assert property (apply_in && !stop_in && !armed_out && idle
        && trig_src_in == `VTA_SRC_NONE |=> ##1 running_out)
        else $error("no start after apply without trigger");
    chk_start_armed: assert property ($rose(running_out) |-> $past(armed_out))
        else $error("cycle started while not armed");
    chk_dig_start: assert property (dig_on && din_in[trig_ch_in] == dig_active_high_in
        |-> ##[1:3] running_out)
        else $error("active digital level did not start");
    chk_dig_hold: assert property ((dig_on && din_in[trig_ch_in] != dig_active_high_in)[*3]
        |=> !running_out)
        else $error("inactive digital level started a cycle");
    chk_stop_disarm: assert property (stop_in |=> !armed_out)
        else $error("stop did not disarm");
endmodule : vta_ctrl_assertions
bind vta_ctrl vta_ctrl_assertions chk (.clk_in, .reset_n_in, .apply_in, .stop_in, .trig_src_in,
    .trig_ch_in, .dig_active_high_in, .din_in, .alarm_out, .running_out, .armed_out,
    .phase_out, .cycle_done_out);
`default_nettype wire

// ### bench/vta_ctrl_tb.sv
// Self-checking testbench of the trigger and alarm controller
`timescale 1ns/1ps
`default_nettype none
`include "vta_consts.svh"
module vta_ctrl_tb;
    import vta_pkg::*;
    logic clk = 0, rst_n = 0, apply = 0, stop = 0, hi = 1, above = 1, sv, run, armed, done;
    logic [1:0] mode = 0, src = 0, ch = 0;
    logic [3:0] lvl = 4'hF, fv_in = 4'h0, din, alarm, fvo;
    logic [4:0] fe = 5'h01;
    logic [7:0] filt = 8'h04;
    logic [15:0] amp = 16'h00C8, cnt = 16'h0001, iters;
    vta_smp_vec_t smp, fmx;
    vta_phase_t ph;
    int fail_count = 0, checks_done = 0;
    always #20 clk = ~clk;
    vta_sensor far (.clk_in(clk), .amp_in(amp), .lvl_in(lvl), .din_out(din),
        .sample_out(smp), .sample_valid_out(sv));
    vta_ctrl dut (.clk_in(clk), .reset_n_in(rst_n), .apply_in(apply), .stop_in(stop),
        .mode_in(mode), .trig_src_in(src), .trig_ch_in(ch), .dig_active_high_in(hi),
        .ana_above_in(above), .trig_level_in(16'h0064), .filter_len_in(filt),
        .section_len_in(12'h002), .cycle_count_in(cnt), .din_in(din), .sample_in(smp),
        .sample_valid_in(sv), .feat_en_in(fe), .feat_limit_in({5{16'h0064}}),
        .fail_verdict_in(fv_in), .window_len_in(8'h02), .score_thresh_in(7'h32),
        .alarm_out(alarm), .fail_verdict_out(fvo), .running_out(run), .armed_out(armed),
        .phase_out(ph), .cycle_done_out(done), .iter_count_out(iters), .feat_max_out(fmx),
        .feat_min_out(), .feat_peak_out(), .feat_p2p_out());
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic go(input logic [1:0] m, input logic [1:0] s, input logic [15:0] c);
        @(negedge clk) {mode, src, cnt, apply} = {m, s, c, 1'b1};
        @(negedge clk) apply = 0;
    endtask : go
    task automatic wait_done();
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
        check("cycle_done", done, 1);
        @(negedge clk);
    endtask : wait_done
    task automatic quiet(input int n);
        repeat (n) @(negedge clk) check("running", run, 0);
    endtask : quiet
    task automatic halt();
        @(negedge clk) stop = 1;
        for (int i = 0; i < 300 && run !== 1'b0; i++) @(negedge clk);
        @(negedge clk) stop = 0;
        check("armed", armed, 0);
    endtask : halt
    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results
    initial begin
        #400000 fail_count++;
        results();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        check("alarm", alarm, 0);
        check("phase", ph, VTA_IDLE);
        go(`VTA_MODE_FEAT, `VTA_SRC_NONE, 1);
        wait_done();
        check("alarm", alarm, 4'hF);
        check("iterations", iters, 1);
        check("max", fmx[0], 16'h00C8);
        quiet(10);
        $display("Test burst feature done");
        {amp, fe} = {16'h0032, 5'h1D};
        go(`VTA_MODE_FEAT, `VTA_SRC_NONE, 1);
        wait_done();
        check("alarm", alarm, 4'h0);
        {hi, ch} = {1'b0, 2'h1};
        go(`VTA_MODE_FEAT, `VTA_SRC_DIG, 1);
        quiet(20);
        lvl = 4'hD;
        for (int i = 0; i < 20 && run !== 1'b1; i++) @(negedge clk);
        check("running", run, 1);
        @(negedge clk) lvl = 4'hF;
        @(negedge clk) lvl = 4'hD;
        @(negedge clk) lvl = 4'hF;
        wait_done();
        quiet(10);
        halt();
        $display("Test digital trigger done");
        go(`VTA_MODE_FEAT, `VTA_SRC_ANA, 1);
        quiet(30);
        above = 0;
        wait_done();
        halt();
        $display("Test analog trigger done");
        fv_in = 4'h1;
        go(`VTA_MODE_INF, `VTA_SRC_NONE, 2);
        wait_done();
        check("alarm", alarm, 4'h1);
        check("verdict", fvo, 4'h1);
        fv_in = 4'h0;
        wait_done();
        check("alarm", alarm, 4'h0);
        go(`VTA_MODE_LOG, `VTA_SRC_NONE, 1);
        fv_in = 4'hF;
        wait_done();
        check("verdict", fvo, 4'h0);
        $display("Test inference and logging done");
        {amp, fe} = {16'h00C8, 5'h01};
        go(`VTA_MODE_FEAT, `VTA_SRC_NONE, 0);
        wait_done();
        wait_done();
        halt();
        quiet(10);
        $display("Test continuous done");
        results();
    end
endmodule : vta_ctrl_tb
`default_nettype wire
